// >>> hdl/oscillator_mode_select.v
// What this block does
// RULE1: mode, prescale, divider come from fixed configuration
// RULE2: eight modes chosen by three-bit field
// RULE3: clock output toggles at quarter peripheral rate
// RULE4: clock output stops in sleep, runs idle
// RULE5: ext clock pll mode: software pll, clkout
// RULE6: ext clock mode: pll off, clkout on bit6
// RULE7: crystal modes need parallel-cut crystal across pins
// RULE8: crystal mode pll off; crystal pll software
// RULE9: int pll clkout: software pll, bit7 port
// RULE10: int pll mode: both pins are ports
// RULE11: int clkout mode: pll off, bit7 port
// RULE12: plain internal mode: pll off, both ports
// RULE13: feed pll only from 8 or 4 MHz
// RULE14: clock-select register picks the active source
// RULE15: trim register tunes, picks slow source, pll; only the pll bit (bit 6) is used here
// RULE16: after reset mux follows programmed mode
// RULE17: pll switch waits lock time, then automatic
// RULE18: internal pll only modes 011/010, freq 111/110
// RULE19: cpu divider one, two, three or six
// RULE20: external clock modes need no start-up delay
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "osc_mode_defs.vh"

module oscillator_mode_select #(
	parameter PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
)(
	input wire clk,
	input wire resetn,
	input wire [2:0] osc_mode_select,
	input wire [1:0] cpu_divider_bits,
	input wire sleep_mode,
	input wire osc_ready,
	input wire [31:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_stb_i,
	input wire wb_cyc_i,
	output reg wb_ack_o,
	output reg clock_out_pin,
	output reg clock_out_en_n,
	output reg bit6_is_port,
	output reg bit7_is_port,
	output reg osc_pins_used,
	output reg pll_on,
	output reg pll_clock_active,
	output reg [1:0] active_source,
	output reg [2:0] cpu_div_ratio,
	output reg clock_stable,
	output reg [3:0] pll_tick
);

	// ------------------------------------------------------------
	// configuration capture
	// ------------------------------------------------------------
	reg [2:0] mode_r;
	reg [1:0] cpudiv_r;
	reg cfg_loaded_r;
	reg [2:0] slp_sync_r;
	reg sleep_r;
	reg [7:0] sel_r;
	reg [7:0] trim_r;
	reg [23:0] lock_cnt_r;
	reg locked_r;
	reg [1:0] quarter_r;
	reg [2:0] div_cnt_r;
	reg [4:0] strap_a_r;
	reg [4:0] strap_b_r;
	reg [4:0] strap_c_r;
	reg [1:0] fill_r;
	reg [2:0] rdy_sync_r;
	reg ready_r;
	wire pll_allowed;
	wire pll_req;
	wire clkout_mode;
	wire ext_mode;
	wire int_mode;
	wire wb_hit;
	wire wb_in_map;
	reg [31:0] rd_nxt;

	// straps are pins: three stages, and a fill count so reset zeros never pass as a mode
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_a_r <= 5'h00;
			strap_b_r <= 5'h00;
			strap_c_r <= 5'h00;
			fill_r <= 2'h0;
		end
		else
		begin
			strap_a_r <= {cpu_divider_bits, osc_mode_select};
			strap_b_r <= strap_a_r;
			strap_c_r <= strap_b_r;
			if (fill_r != 2'h3)
				fill_r <= fill_r + 2'h1;
		end
	end

	// straps taken once after release; they never change until the next reset
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_r <= 3'h0;
			cpudiv_r <= 2'h0;
			cfg_loaded_r <= 1'b0;
		end
		else if (!cfg_loaded_r && (fill_r == 2'h3) && (strap_b_r == strap_c_r))
		begin
			mode_r <= strap_c_r[2:0]; // RULE1 RULE2
			cpudiv_r <= strap_c_r[4:3]; // RULE1
			cfg_loaded_r <= 1'b1;
		end
	end

	// sleep comes from another domain: three stages, second and third agree
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			slp_sync_r <= 3'h0;
			sleep_r <= 1'b0;
		end
		else
		begin
			slp_sync_r <= {slp_sync_r[1:0], sleep_mode};
			if (slp_sync_r[1] == slp_sync_r[2])
				sleep_r <= slp_sync_r[2];
		end
	end

	// crystal ready comes from the oscillator's own domain: same three stages
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdy_sync_r <= 3'h0;
			ready_r <= 1'b0;
		end
		else
		begin
			rdy_sync_r <= {rdy_sync_r[1:0], osc_ready};
			if (rdy_sync_r[1] == rdy_sync_r[2])
				ready_r <= rdy_sync_r[2];
		end
	end

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	assign ext_mode = (mode_r == `MODE_EXT_CLOCK) || (mode_r == `MODE_EXT_CLOCK_PLL);
	assign int_mode = (mode_r[2] == 1'b0);
	// clkout only in ext and int clkout modes
	assign clkout_mode = ext_mode || (mode_r == `MODE_INT_OSC_CLKOUT) // RULE5 RULE6 RULE11
		|| (mode_r == `MODE_INT_OSC_PLL_CLKOUT); // RULE9
	// pll permitted only in the software-pll modes
	assign pll_allowed = (mode_r == `MODE_EXT_CLOCK_PLL) // RULE5 RULE6
		|| (mode_r == `MODE_CRYSTAL_PLL) // RULE8
		|| (((mode_r == `MODE_INT_OSC_PLL) || (mode_r == `MODE_INT_OSC_PLL_CLKOUT)) // RULE9 RULE10
		&& (sel_r[1:0] == `SCS_PRIMARY)
		&& ((sel_r[6:4] == `INT_OSC_FREQ_SELECT_8MHZ) || (sel_r[6:4] == `INT_OSC_FREQ_SELECT_4MHZ))); // RULE18 RULE13
	assign pll_req = cfg_loaded_r && pll_allowed && trim_r[`TRIM_PLL_ENABLE_BIT_BIT]; // RULE15

	// ------------------------------------------------------------
	// wishbone slave: one wait state, ack drops the cycle after
	// ------------------------------------------------------------
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// only the low sixteen bytes decode; aliases above read zero
	assign wb_in_map = (wb_adr_i[31:4] == 28'h0000000);

	always @*
	begin
		rd_nxt = 32'h0;
		case (wb_adr_i[3:0])
			`ADDR_CLOCK_SELECT: rd_nxt = {24'h0, sel_r}; // RULE14
			`ADDR_OSC_TRIM: rd_nxt = {24'h0, trim_r};
			`ADDR_STATUS: rd_nxt = {28'h0, clock_stable, locked_r, pll_req, sleep_r};
			`ADDR_CONFIG: rd_nxt = {27'h0, cpudiv_r, mode_r};
			default: rd_nxt = 32'h0;
		endcase
	end

	// unmapped addresses ack with zero data and ignore writes
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			sel_r <= `CLOCK_SELECT_RESET;
			trim_r <= `OSC_TRIM_RESET;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			if (wb_hit)
				wb_dat_o <= wb_in_map ? rd_nxt : 32'h0;
			if (wb_hit && wb_we_i && wb_sel_i[0] && wb_in_map)
			begin
				if (wb_adr_i[3:0] == `ADDR_CLOCK_SELECT)
					sel_r <= wb_dat_i[7:0]; // RULE14
				if (wb_adr_i[3:0] == `ADDR_OSC_TRIM)
					trim_r <= wb_dat_i[7:0]; // RULE15
			end
		end
	end

	// ------------------------------------------------------------
	// pll lock timer: core stays on old clock until it expires
	// ------------------------------------------------------------
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lock_cnt_r <= 24'h0;
			locked_r <= 1'b0;
		end
		else if (!pll_req)
		begin
			lock_cnt_r <= 24'h0; // dropping the request loses lock at once
			locked_r <= 1'b0;
		end
		else if (!locked_r)
		begin
			if (lock_cnt_r == PLL_LOCK_CYCLES[23:0] - 24'h1)
				locked_r <= 1'b1; // RULE17
			lock_cnt_r <= lock_cnt_r + 24'h1;
		end
	end

	// ------------------------------------------------------------
	// clock output: quarter rate, halted in sleep
	// ------------------------------------------------------------
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			quarter_r <= 2'h0;
			clock_out_pin <= 1'b0;
			clock_out_en_n <= 1'b1;
		end
		else
		begin
			clock_out_en_n <= !(cfg_loaded_r && clkout_mode);
			if (cfg_loaded_r && clkout_mode && !sleep_r) // RULE4
			begin
				quarter_r <= quarter_r + 2'h1;
				if (quarter_r[0])
					clock_out_pin <= !clock_out_pin; // RULE3
			end
		end
	end

	// ------------------------------------------------------------
	// pin roles, source selection, cpu divider
	// ------------------------------------------------------------
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bit6_is_port <= 1'b1;
			bit7_is_port <= 1'b1;
			osc_pins_used <= 1'b0;
			pll_on <= 1'b0;
			pll_clock_active <= 1'b0;
			active_source <= 2'h0;
			cpu_div_ratio <= 3'h1;
			clock_stable <= 1'b0;
		end
		else
		begin
			bit6_is_port <= int_mode && !clkout_mode; // RULE10 RULE12
			bit7_is_port <= int_mode; // RULE9 RULE11
			osc_pins_used <= !int_mode; // RULE7
			pll_on <= pll_req; // RULE6 RULE8 RULE11 RULE12
			pll_clock_active <= pll_req && locked_r; // RULE17
			// primary source set by mode unless software switched
			active_source <= (sel_r[1:0] == `SCS_PRIMARY) ? (int_mode ? 2'h0 : 2'h1) // RULE16
				: sel_r[1:0];
			case (cpudiv_r)
				2'h0: cpu_div_ratio <= 3'h6; // RULE19
				2'h1: cpu_div_ratio <= 3'h3;
				2'h2: cpu_div_ratio <= 3'h2;
				default: cpu_div_ratio <= 3'h1;
			endcase
			// external clock is usable at once, crystal waits for ready
			clock_stable <= cfg_loaded_r && (ext_mode || int_mode || ready_r); // RULE20
		end
	end

	// divided-clock tick for the cpu, counted at the chosen ratio
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_cnt_r <= 3'h0;
			pll_tick <= 4'h0;
		end
		else
		begin
			if (div_cnt_r >= cpu_div_ratio - 3'h1)
				div_cnt_r <= 3'h0; // RULE19
			else
				div_cnt_r <= div_cnt_r + 3'h1;
			pll_tick <= {pll_tick[2:0], (div_cnt_r == 3'h0)};
		end
	end

endmodule // oscillator_mode_select

// >>> pkg/osc_mode_defs.vh
`ifndef OSC_MODE_DEFS_VH
`define OSC_MODE_DEFS_VH

// ----------------------------------------------------------------
// oscillator mode encodings (3-bit configuration field)
// ----------------------------------------------------------------
`define MODE_INT_OSC 3'h0
`define MODE_INT_OSC_CLKOUT 3'h1
`define MODE_INT_OSC_PLL 3'h2
`define MODE_INT_OSC_PLL_CLKOUT 3'h3
`define MODE_CRYSTAL 3'h4
`define MODE_CRYSTAL_PLL 3'h5
`define MODE_EXT_CLOCK 3'h6
`define MODE_EXT_CLOCK_PLL 3'h7

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_CLOCK_SELECT 4'h0
`define ADDR_OSC_TRIM 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_CONFIG 4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEL_SCS_LSB 0
`define SEL_INT_OSC_FREQ_SELECT_LSB 4
`define TRIM_TUNE_LSB 0
`define TRIM_PLL_ENABLE_BIT_BIT 6
`define TRIM_INTSRC_BIT 7
`define INT_OSC_FREQ_SELECT_8MHZ 3'h7
`define INT_OSC_FREQ_SELECT_4MHZ 3'h6
`define SCS_PRIMARY 2'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CLOCK_SELECT_RESET 8'h70
`define OSC_TRIM_RESET 8'h00

// ----------------------------------------------------------------
// timing: pll lock time, 50 MHz clock
// ----------------------------------------------------------------
`define PLL_LOCK_US 2000
`define CLK_MHZ 50
`define PLL_LOCK_CYCLES (`PLL_LOCK_US * `CLK_MHZ)

`endif

// >>> dv/osc_source_model.sv
`timescale 1ns/10ps
// stands in for the part on the oscillator pins
module osc_source_model #(
	parameter [3:0] START = 4'h8
)(
	input wire clk,
	input wire resetn,
	input wire [2:0] mode,
	output reg osc_ready
);
	reg [3:0] cnt_r;
	// a crystal needs time to swing up after reset
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt_r <= 4'h0;
		else if (cnt_r != START)
			cnt_r <= cnt_r + 4'h1;
	end
	// an external clock is there at once; internal modes leave the pins alone
	always @*
		osc_ready = mode[2:1] == 2'h3 || (mode[2:1] == 2'h2 && cnt_r == START);
endmodule // osc_source_model

// >>> dv/osc_mode_chk.sv
`timescale 1ns/10ps
// pin roles, pll gating and clock-out timing against the straps
module osc_mode_chk #(
	parameter PLL_LOCK_CYCLES = 20
)(
	input wire clk,
	input wire resetn,
	input wire [2:0] osc_mode_select,
	input wire [1:0] cpu_divider_bits,
	input wire sleep_mode,
	input wire clock_out_pin,
	input wire clock_out_en_n,
	input wire bit6_is_port,
	input wire bit7_is_port,
	input wire pll_on,
	input wire pll_clock_active,
	input wire [2:0] cpu_div_ratio
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire [2:0] m = osc_mode_select;
	wire [1:0] d = cpu_divider_bits;
	reg [2:0] up_r;
	reg [23:0] wait_r;
	// straps land a few edges after release, so role checks wait for them
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			up_r <= 3'h0;
		else if (up_r != 3'h7)
			up_r <= up_r + 3'h1;
	end
	wire ok = up_r == 3'h7;
	// cycles spent enabled but not yet switched over to the pll
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wait_r <= 24'h0;
		else if (!pll_on || pll_clock_active)
			wait_r <= 24'h0;
		else
			wait_r <= wait_r + 24'h1;
	end
	a_pll_forced_off: assert property (!(m[2] ? m[0] : m[1]) |-> !pll_on)
		else $error("pll on in a fixed mode");
	a_clkout_drive: assert property (ok |-> clock_out_en_n == !(m[2] ? m[1] : m[0]))
		else $error("clock out enable wrong");
	a_port_roles: assert property
		(ok |-> bit6_is_port == !(m[2] | m[0]) && bit7_is_port == !m[2])
		else $error("pin role wrong");
	a_quarter_rate: assert property ($changed(clock_out_pin) |=> $stable(clock_out_pin))
		else $error("clock out too fast");
	a_sleep_freeze: assert property (sleep_mode [*8] |-> $stable(clock_out_pin))
		else $error("clock out runs in sleep");
	a_lock_wait: assert property ($rose(pll_on) |=> !pll_clock_active [*8])
		else $error("pll clock before lock");
	a_lock_bound: assert property ($rose(pll_on) |-> ##[1:40] (pll_clock_active || !pll_on))
		else $error("pll never switched");
	a_lock_count: assert property ($rose(pll_clock_active) |-> wait_r == PLL_LOCK_CYCLES)
		else $error("pll switched after wrong lock time");
	a_cpu_div: assert property
		(ok |-> cpu_div_ratio == (d == 2'h0 ? 3'h6 : d == 2'h1 ? 3'h3 : 3'h4 - {1'b0, d}))
		else $error("cpu divider wrong");
endmodule // osc_mode_chk

bind oscillator_mode_select osc_mode_chk #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_chk (.clk,
	.resetn, .osc_mode_select, .cpu_divider_bits, .sleep_mode, .clock_out_pin, .clock_out_en_n,
	.bit6_is_port, .bit7_is_port, .pll_on, .pll_clock_active, .cpu_div_ratio);

// >>> dv/tb_oscillator_mode_select.sv
`timescale 1ns/10ps
module tb_oscillator_mode_select;
	logic clk = 0, resetn = 0, sleep_mode = 0, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0;
	logic [2:0] osc_mode_select = 3'h0;
	logic [1:0] cpu_divider_bits = 2'h0;
	logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, rd;
	logic [3:0] wb_sel_i = 4'hF;
	wire [31:0] wb_dat_o;
	wire [2:0] cpu_div_ratio;
	wire osc_ready, wb_ack_o, clock_out_pin, clock_out_en_n, bit6_is_port, bit7_is_port;
	wire pll_on, pll_clock_active, clock_stable, osc_pins_used;
	wire [1:0] active_source;
	wire [3:0] pll_tick;
	int err_total = 0, total_checks = 0;
	always #10 clk = ~clk;
	oscillator_mode_select #(.PLL_LOCK_CYCLES(20)) DUT (.*);
	osc_source_model SRC (.clk, .resetn, .mode(osc_mode_select), .osc_ready);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// classic cycle: everything held until ack is sampled, then let go
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk);
		wb_adr_i <= {24'h0, a};
		wb_we_i <= w;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		while (wb_ack_o !== 1'b1)
			@(posedge clk);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		wb_we_i <= 0;
		chk("ack", 1, wb_ack_o);
	endtask
	// straps only count as they stand on the first edges after release
	task automatic boot(input logic [2:0] m, input logic [1:0] d);
		@(posedge clk);
		resetn <= 0;
		osc_mode_select <= m;
		cpu_divider_bits <= d;
		repeat (2) @(posedge clk);
		resetn <= 1;
		repeat (8) @(posedge clk);
	endtask
	task automatic toggles(output int c);
		logic p;
		c = 0;
		@(posedge clk);
		p = clock_out_pin;
		repeat (16)
		begin
			@(posedge clk);
			c += (clock_out_pin !== p);
			p = clock_out_pin;
		end
	endtask
	task automatic test_modes;
		logic [2:0] m;
		logic cap;
		int r, n;
		for (int i = 0; i < 8; i++)
		begin
			m = i[2:0];
			cap = m[2] ? m[0] : m[1];
			r = i[1:0] == 0 ? 6 : i[1:0] == 1 ? 3 : 4 - i[1:0];
			boot(m, i[1:0]);
			chk("bit6 port", !(m[2] | m[0]), bit6_is_port);
			chk("bit7 port", !m[2], bit7_is_port);
			chk("clkout en_n", !(m[2] ? m[1] : m[0]), clock_out_en_n);
			chk("ratio", r, cpu_div_ratio);
			chk("source", {1'b0, m[2]}, active_source);
			chk("osc pins", m[2], osc_pins_used);
			chk("stable at boot", m[2:1] != 2'h2, clock_stable);
			bus(8'h0C, 0, 8'h0, 4'hF);
			chk("config", {27'h0, i[1:0], m}, rd);
			bus(8'h04, 1, 8'h40, 4'hF);
			repeat (2) @(posedge clk);
			chk("early pll clock", 0, pll_clock_active);
			repeat (40) @(posedge clk);
			chk("pll on", cap, pll_on);
			chk("pll clock", cap, pll_clock_active);
			bus(8'h08, 0, 8'h0, 4'hF);
			chk("status", {28'h0, 1'b1, cap, cap, 1'b0}, rd);
			n = 0;
			repeat (12)
			begin
				@(posedge clk);
				n += pll_tick[3];
			end
			chk("cpu ticks", 12 / r, n);
		end
		$display("modes test done");
	endtask
	task automatic test_regs;
		boot(3'h2, 2'h3);
		bus(8'h00, 0, 8'h0, 4'hF);
		chk("select reset", 32'h70, rd);
		bus(8'h04, 0, 8'h0, 4'hF);
		chk("trim reset", 32'h0, rd);
		bus(8'h10, 0, 8'h0, 4'hF);
		chk("unmapped", 32'h0, rd);
		bus(8'h04, 1, 8'h40, 4'h0);
		bus(8'h04, 0, 8'h0, 4'hF);
		chk("masked write", 32'h0, rd);
		bus(8'h00, 1, 8'h50, 4'hF);
		bus(8'h04, 1, 8'h40, 4'hF);
		repeat (40) @(posedge clk);
		chk("pll off freq", 0, pll_on);
		bus(8'h00, 1, 8'h60, 4'hF);
		repeat (40) @(posedge clk);
		chk("pll on 4 MHz", 1, pll_on);
		bus(8'h00, 0, 8'h0, 4'hF);
		chk("select back", 32'h60, rd);
		$display("register test done");
	endtask
	task automatic test_clkout;
		int c;
		boot(3'h0, 2'h3);
		toggles(c);
		chk("no clkout", 0, c);
		boot(3'h1, 2'h3);
		toggles(c);
		chk("quarter rate", 8, c);
		sleep_mode <= 1;
		repeat (8) @(posedge clk);
		toggles(c);
		chk("sleep stop", 0, c);
		sleep_mode <= 0;
		repeat (8) @(posedge clk);
		toggles(c);
		chk("wake rate", 8, c);
		$display("clock out test done");
	endtask
	initial
	begin
		test_modes;
		test_regs;
		test_clkout;
		conclude;
	end
	// the tests need about a thousand cycles; this limit is ten times that
	initial
	begin
		#200us;
		err_total++;
		conclude;
	end
endmodule // tb_oscillator_mode_select
